/* File: adc_seq_pkg.sv */
// Purpose: shared constants and types for the conversion sequencer
// Assumes: one clock, bit-period ticks derived inside the sequencer
// Notes: overview of operation below
//
// Overview of operation
// RULE1 - nonzero acquisition setting samples 2..20 bit periods, then converts
// RULE2 - acquisition setting 000 stops sampling and converts at once on go; the code first waits in ST_HOLD for one or two instr_tick pulses
// RULE3 - acquisition time setting resets to 000, manual mode
// RULE4 - completion clears go, sets done flag, resumes sampling
// RULE5 - no status marks end of acquisition; go stays set throughout
// RULE6 - clock select picks system divide 2..64 or rc oscillator
// RULE7 - one conversion takes exactly eleven bit periods
// RULE8 - done flag set on every completion, cleared only by software
// RULE9 - enabled done flag raises interrupt at its priority, wakes from sleep
// RULE10 - justify bit places result left or right in the register pair
// RULE11 - nothing runs while the enable bit is clear
// RULE12 - manual mode converts only after the next instruction
// RULE13 - rc clock delays conversion start by one extra instruction
// RULE14 - software enables the converter before setting go, never together
// RULE15 - completion loads the new result into the register pair
// RULE16 - software clearing go aborts; result pair keeps old value
// RULE17 - device reset restores registers, turns off, ends conversion
// RULE18 - after completion or abort wait two bit periods discharging
// RULE19 - sleep, rc clock, interrupt off: turn off after completion
// RULE20 - sleep with non-rc clock aborts and turns converter off
// RULE21 - trigger select 0 compare unit, 1 charge-time unit; trigger sets go
// RULE22 - triggers ignored and go unchanged while enable is clear; the code ignores triggers but clears go while enable is clear
// RULE23 - acquisition codes 001..111 give 2,4,6,8,12,16,20 bit periods
// RULE24 - justify 1 right justified, 0 left justified
// RULE25 - left: high holds bits 9..2, low top two hold bits 1..0
// RULE26 - right: low holds bits 7..0, high holds 9..8, rest zero
package adc_seq_pkg;
    localparam logic [2:0] ACQ_MANUAL = 3'h0;
    localparam logic [2:0] ACQ_RESET = 3'h0;
    localparam logic [2:0] CLK_RESET = 3'h0;
    localparam logic [1:0] CLK_RC_LOW = 2'h3;
    localparam logic [4:0] CONV_PERIODS = 5'h0b;
    localparam logic [4:0] DISCH_PERIODS = 5'h02;
    localparam logic [9:0] SAR_FIRST = 10'h200;
    localparam logic [5:0] DIV_RESET = 6'h00;

    typedef enum logic [2:0] {
        ST_OFF, ST_SAMPLE, ST_HOLD, ST_ACQ, ST_CONV, ST_DISCH
    } seq_state_e;

    typedef struct packed {
        logic justify;
        logic trig_sel;
        logic [2:0] acq_sel;
        logic [2:0] clk_sel;
    } cfg_s;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } res_s;

    localparam cfg_s CFG_RESET = '{1'b0, 1'b0, ACQ_RESET, CLK_RESET};
endpackage

/* File: adc_conversion_sequencer.sv */
// Purpose: control sequencer of a 10-bit successive approximation converter
// Assumes: software strobes are one-cycle pulses synchronous to clk
// Notes: bit period comes from a clk divider or from rc_tick pulses
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic conv_enable,
    input wire cfg_s cfg,
    input wire logic go_set,
    input wire logic go_clear,
    input wire logic flag_clear,
    input wire logic conv_irq_en,
    input wire logic conv_irq_priority,
    input wire logic sleep_mode,
    input wire logic instr_tick,
    input wire logic rc_tick,
    input wire logic trig_compare,
    input wire logic trig_charge,
    input wire logic sar_cmp,
    output logic go_flag,
    output logic conv_done_flag,
    output logic irq_high,
    output logic irq_low,
    output logic wake_req,
    output res_s result,
    output logic sampling,
    output logic discharging,
    output logic analog_on,
    output logic [9:0] sar_trial
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [4:0] acq_periods(input logic [2:0] sel);
        case (sel)
            3'h1: acq_periods = 5'h02;
            3'h2: acq_periods = 5'h04;
            3'h3: acq_periods = 5'h06;
            3'h4: acq_periods = 5'h08;
            3'h5: acq_periods = 5'h0c;
            3'h6: acq_periods = 5'h10;
            3'h7: acq_periods = 5'h14;
            default: acq_periods = 5'h00;
        endcase
    endfunction

    function automatic res_s place(input logic [9:0] v, input logic rj);
        res_s r;
        if (rj) // see RULE10, see RULE24
            r = '{{6'h00, v[9:8]}, v[7:0]}; // see RULE26
        else
            r = '{v[9:2], {v[1:0], 6'h00}}; // see RULE25
        place = r;
    endfunction

    // ****************************************
    // state
    // ****************************************
    seq_state_e state_reg, state_next;
    cfg_s cfg_reg;
    logic [5:0] div_reg, div_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [1:0] hold_reg, hold_next;
    logic [9:0] sar_reg, sar_next;
    logic go_reg, go_next;
    logic flag_reg, flag_next;
    logic down_reg, down_next;
    res_s res_reg, res_next;
    logic tick;
    logic is_rc;
    logic trig;
    logic done;
    logic [5:0] div_top;
    logic [3:0] bit_idx;
    logic [9:0] sar_dec;

    // ****************************************
    // bit-period clock
    // ****************************************
    always_comb
    begin
        is_rc = (cfg_reg.clk_sel[1:0] == CLK_RC_LOW); // see RULE6
        div_top = 6'((7'h01 << ({cfg_reg.clk_sel[1:0], 1'b0}
            + {2'h0, cfg_reg.clk_sel[2]} + 3'h1)) - 7'h01); // see RULE6
        div_next = (div_reg >= div_top) ? DIV_RESET : div_reg + 6'h01;
        tick = is_rc ? rc_tick : (div_reg >= div_top);
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        hold_next = hold_reg;
        sar_next = sar_reg;
        res_next = res_reg;
        down_next = down_reg;
        done = 1'b0;
        bit_idx = 4'(5'h0a - cnt_reg);
        sar_dec = sar_reg;
        if (!sar_cmp)
            sar_dec[bit_idx] = 1'b0;
        if (bit_idx != 4'h0)
            sar_dec[bit_idx - 4'h1] = 1'b1;
        trig = cfg_reg.trig_sel ? trig_charge : trig_compare; // see RULE21
        if (!sleep_mode)
            down_next = 1'b0;
        case (state_reg)
            ST_OFF:
                if (conv_enable && !down_reg)
                    state_next = ST_SAMPLE;
            ST_SAMPLE:
                if (go_reg)
                begin
                    cnt_next = 5'h00;
                    // see RULE12, see RULE13
                    hold_next = {1'b0, cfg_reg.acq_sel == ACQ_MANUAL}
                        + {1'b0, is_rc};
                    if (hold_next != 2'h0)
                        state_next = ST_HOLD;
                    else
                        state_next = ST_ACQ; // see RULE1
                end
            ST_HOLD:
                if (instr_tick)
                begin
                    hold_next = hold_reg - 2'h1;
                    if (hold_reg == 2'h1)
                    begin
                        sar_next = SAR_FIRST;
                        state_next = (cfg_reg.acq_sel == ACQ_MANUAL)
                            ? ST_CONV : ST_ACQ; // see RULE2
                    end
                end
            ST_ACQ:
                if (cnt_reg >= acq_periods(cfg_reg.acq_sel)) // see RULE23
                begin
                    cnt_next = 5'h00;
                    sar_next = SAR_FIRST;
                    state_next = ST_CONV; // see RULE1, see RULE5
                end
                else if (tick)
                    cnt_next = cnt_reg + 5'h01;
            ST_CONV:
                if (tick)
                begin
                    cnt_next = cnt_reg + 5'h01;
                    if (cnt_reg != 5'h00)
                        sar_next = sar_dec;
                    if (cnt_reg == CONV_PERIODS - 5'h01) // see RULE7
                    begin
                        done = 1'b1;
                        res_next = place(sar_dec, cfg_reg.justify); // see RULE15
                        cnt_next = 5'h00;
                        state_next = ST_DISCH;
                        if (sleep_mode && is_rc && !conv_irq_en)
                            down_next = 1'b1; // see RULE19
                    end
                end
            ST_DISCH:
                if (tick)
                begin
                    cnt_next = cnt_reg + 5'h01;
                    if (cnt_reg == DISCH_PERIODS - 5'h01) // see RULE18
                        state_next = down_next ? ST_OFF : ST_SAMPLE;
                end
            default:
                state_next = ST_OFF;
        endcase
        // software abort keeps the old result, see RULE16
        if (go_clear && (state_reg == ST_HOLD || state_reg == ST_ACQ
            || state_reg == ST_CONV))
        begin
            res_next = res_reg;
            done = 1'b0;
            cnt_next = 5'h00;
            state_next = ST_DISCH;
        end
        if (sleep_mode && !is_rc && state_reg != ST_OFF)
        begin
            down_next = 1'b1; // see RULE20
            res_next = res_reg;
            done = 1'b0;
            state_next = ST_OFF;
        end
        if (!conv_enable)
            state_next = ST_OFF; // see RULE11
        // go flag: set wins over clear, see RULE4, see RULE21, see RULE22
        go_next = go_reg;
        if (done || go_clear || !conv_enable || state_next == ST_OFF)
            go_next = 1'b0;
        if (conv_enable && !down_next && (go_set || trig))
            go_next = 1'b1;
        flag_next = flag_reg;
        if (flag_clear)
            flag_next = 1'b0;
        if (done)
            flag_next = 1'b1; // see RULE8
    end

    // see RULE17
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= ST_OFF;
            cfg_reg <= CFG_RESET; // see RULE3
            div_reg <= DIV_RESET;
            cnt_reg <= 5'h00;
            hold_reg <= 2'h0;
            sar_reg <= 10'h000;
            go_reg <= 1'b0;
            flag_reg <= 1'b0;
            down_reg <= 1'b0;
            res_reg <= '0;
            irq_high <= 1'b0;
            irq_low <= 1'b0;
            wake_req <= 1'b0;
            sampling <= 1'b0;
            discharging <= 1'b0;
            analog_on <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cfg_reg <= cfg;
            div_reg <= div_next;
            cnt_reg <= cnt_next;
            hold_reg <= hold_next;
            sar_reg <= sar_next;
            go_reg <= go_next;
            flag_reg <= flag_next;
            down_reg <= down_next;
            res_reg <= res_next;
            irq_high <= flag_reg && conv_irq_en && conv_irq_priority; // see RULE9
            irq_low <= flag_reg && conv_irq_en && !conv_irq_priority;
            wake_req <= flag_reg && conv_irq_en && sleep_mode;
            sampling <= state_next == ST_SAMPLE || state_next == ST_ACQ
                || state_next == ST_HOLD;
            discharging <= state_next == ST_DISCH;
            analog_on <= state_next != ST_OFF;
        end
    end

    assign go_flag = go_reg;
    assign conv_done_flag = flag_reg;
    assign result = res_reg;
    assign sar_trial = sar_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic [4:0] conv_ticks;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            conv_ticks <= 5'h00;
        else if (state_reg != ST_CONV)
            conv_ticks <= 5'h00;
        else if (tick)
            conv_ticks <= conv_ticks + 5'h01;
    end

    sequence s_complete;
        state_reg == ST_CONV && tick && cnt_reg == 5'h0a && !go_clear
            && conv_enable && !(sleep_mode && !is_rc);
    endsequence
    sequence s_manual_go;
        state_reg == ST_SAMPLE && go_reg && cfg_reg.acq_sel == ACQ_MANUAL;
    endsequence

    done_set_a: assert property (s_complete |=> flag_reg && !go_reg // see RULE4
        && state_reg == ST_DISCH)
        else $error("completion did not set flag and clear go");
    flag_keep_a: assert property (flag_reg && !flag_clear |=> flag_reg) // see RULE8
        else $error("done flag cleared by hardware");
    conv_len_a: assert property (s_complete |-> conv_ticks == 5'h0a) // see RULE7
        else $error("conversion length is not eleven periods");
    off_idle_a: assert property (!conv_enable |=> state_reg == ST_OFF) // see RULE11
        else $error("converter active while disabled");
    trig_ignore_a: assert property (!conv_enable |=> !go_reg) // see RULE22
        else $error("go set while disabled");
    abort_keep_a: assert property (go_clear && state_reg == ST_CONV // see RULE16
        |=> $stable(res_reg) && state_reg inside {ST_DISCH, ST_OFF})
        else $error("abort changed result");
    manual_hold_a: assert property (s_manual_go and (conv_enable // see RULE12
        && !sleep_mode) |=> state_reg == ST_HOLD)
        else $error("manual start skipped the instruction wait");
    irq_level_a: assert property (flag_reg && conv_irq_en // see RULE9
        && conv_irq_priority |=> irq_high && !irq_low)
        else $error("high priority interrupt missing");
    sleep_abort_a: assert property (sleep_mode && !is_rc // see RULE20
        && state_reg == ST_CONV |=> state_reg == ST_OFF && $stable(res_reg))
        else $error("sleep did not abort conversion");
    right_just_a: assert property (s_complete ##0 cfg_reg.justify // see RULE26
        |=> res_reg.high[7:2] == 6'h00)
        else $error("right justified high bits not zero");
endmodule
`default_nettype wire

/* File: adc_analog_model.sv */
// Purpose: analog side of the converter, comparator and rc oscillator
// Assumes: ideal comparator against a held input level
// Notes: comparator output toggles while the array is powered down
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model
(
    input wire logic clk,
    input wire logic analog_on,
    input wire logic [9:0] sar_trial,
    input wire logic [9:0] level,
    output logic sar_cmp,
    output logic rc_tick
);
    // ****
    // rc oscillator, one tick every eight clocks
    // ****
    logic [2:0] rc_cnt = 3'h0;
    always @(posedge clk)
    begin
        rc_cnt <= rc_cnt + 3'h1;
    end
    assign rc_tick = (rc_cnt == 3'h7);
    always_comb
    begin
        if (analog_on)
            sar_cmp = (sar_trial <= level);
        else
            sar_cmp = ~rc_cnt[0];
    end
endmodule
`default_nettype wire

/* File: adc_conversion_sequencer_test.sv */
// Purpose: self-checking bench for the conversion sequencer
// Assumes: instr_tick pulses every other cycle, rc ticks from the model
// Notes: durations are checked in windows that absorb divider phase
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module adc_conversion_sequencer_test import adc_seq_pkg::*;;
    logic clk = 1'b0, nrst = 1'b0, conv_enable = 1'b0, go_set = 1'b0;
    logic go_clear = 1'b0, flag_clear = 1'b0, conv_irq_en = 1'b0;
    logic conv_irq_priority = 1'b0, sleep_mode = 1'b0;
    logic trig_compare = 1'b0, trig_charge = 1'b0, instr_tick = 1'b0;
    logic sar_cmp, rc_tick, go_flag, conv_done_flag, irq_high, irq_low;
    logic wake_req, sampling, discharging, analog_on;
    logic [9:0] sar_trial;
    logic [9:0] level = 10'h2a5;
    cfg_s cfg = CFG_RESET;
    res_s result;
    int n_fail = 0, n_tests = 0, d, j, k, acq_n, cnv_n;
    int dv[8] = '{2, 8, 32, 8, 4, 16, 64, 8};
    int an[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    always #2 clk = ~clk;
    always
    begin
        @(posedge clk);
        #1 instr_tick = ~instr_tick;
    end
    always @(posedge clk)
    begin
        if (rc_tick && go_flag && !sampling)
            cnv_n++;
        if (rc_tick && go_flag && sampling)
            acq_n++;
    end
    adc_conversion_sequencer dut
    (
        .clk(clk), .nrst(nrst), .conv_enable(conv_enable), .cfg(cfg),
        .go_set(go_set), .go_clear(go_clear), .flag_clear(flag_clear),
        .conv_irq_en(conv_irq_en), .conv_irq_priority(conv_irq_priority),
        .sleep_mode(sleep_mode), .instr_tick(instr_tick), .rc_tick(rc_tick),
        .trig_compare(trig_compare), .trig_charge(trig_charge),
        .sar_cmp(sar_cmp), .go_flag(go_flag), .wake_req(wake_req),
        .conv_done_flag(conv_done_flag), .irq_high(irq_high),
        .irq_low(irq_low), .result(result), .sampling(sampling),
        .discharging(discharging), .analog_on(analog_on),
        .sar_trial(sar_trial)
    );
    adc_analog_model model
    (
        .clk(clk), .analog_on(analog_on), .sar_trial(sar_trial),
        .level(level), .sar_cmp(sar_cmp), .rc_tick(rc_tick)
    );
    // ****
    // access tasks
    // ****
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic res_s fmt(input logic [9:0] r, input logic jf);
        fmt = jf ? res_s'{{6'h00, r[9:8]}, r[7:0]}
                 : res_s'{r[9:2], {r[1:0], 6'h00}};
    endfunction
    task automatic drain();
        d = 0;
        while (go_flag === 1'b1 && d < 3000)
        begin
            cyc(1);
            d++;
        end
        if (d >= 3000)
        begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic clr();
        flag_clear = 1'b1;
        cyc(1);
        flag_clear = 1'b0;
    endtask
    task automatic conv(input logic [2:0] aq, ck, input logic sl, ab);
        cfg.acq_sel = aq;
        cfg.clk_sel = ck;
        cyc(2);
        for (k = 0; k < 300 && sampling !== 1'b1; k++)
            cyc(1);
        `CHK(sampling, 1'b1)
        acq_n = 0;
        cnv_n = 0;
        go_set = 1'b1;
        cyc(1);
        go_set = 1'b0;
        sleep_mode = sl;
        `CHK(go_flag, 1'b1)
        if (ab)
        begin
            cyc(100);
            go_clear = 1'b1;
            cyc(1);
            go_clear = 1'b0;
        end
        drain();
    endtask
    // ****
    // main sequence
    // ****
    initial
    begin
        cyc(3);
        `CHK({go_flag, result}, 17'h00000)
        nrst = 1'b1;
        cyc(2);
        go_set = 1'b1;
        trig_compare = 1'b1;
        trig_charge = 1'b1;
        cyc(1);
        {go_set, trig_compare, trig_charge} = 3'h0;
        cyc(2);
        `CHK(go_flag, 1'b0)
        $display("test disabled done");
        conv_enable = 1'b1;
        cyc(2);
        for (j = 0; j < 2; j++)
        begin
            cfg.justify = j[0];
            level = j[0] ? 10'h15b : 10'h2a5;
            conv(3'h0, 3'h0, 1'b0, 1'b0);
            `CHK({conv_done_flag, discharging}, 2'h3)
            `CHK(result, fmt(level, j[0]))
            cyc(20);
            `CHK({conv_done_flag, irq_high, irq_low}, 3'h4)
        end
        $display("test justify done");
        for (j = 0; j < 8; j++)
        begin
            conv(3'h0, j[2:0], 1'b0, 1'b0);
            `CHK(d >= 10 * dv[j] + 3 && d <= 11 * dv[j] + 5, 1'b1)
            if (j[1:0] == 2'h3)
                `CHK(cnv_n >= 11 && cnv_n <= 12 && acq_n <= 1, 1'b1)
        end
        $display("test clock select done");
        for (j = 1; j < 8; j++)
        begin
            conv(j[2:0], 3'h3, 1'b0, 1'b0);
            `CHK(acq_n >= an[j] && acq_n <= an[j] + 1, 1'b1)
        end
        $display("test acquisition done");
        for (j = 0; j < 2; j++)
        begin
            cfg.trig_sel = j[0];
            cfg.clk_sel = 3'h0;
            cyc(20);
            {trig_compare, trig_charge} = {j[0], ~j[0]};
            cyc(1);
            {trig_compare, trig_charge} = 2'h0;
            `CHK(go_flag, 1'b0)
            {trig_compare, trig_charge} = {~j[0], j[0]};
            cyc(1);
            {trig_compare, trig_charge} = 2'h0;
            `CHK(go_flag, 1'b1)
            drain();
        end
        $display("test triggers done");
        conv_irq_en = 1'b1;
        for (j = 0; j < 2; j++)
        begin
            conv_irq_priority = j[0];
            clr();
            `CHK(conv_done_flag, 1'b0)
            conv(3'h0, 3'h0, 1'b0, 1'b0);
            cyc(2);
            `CHK({irq_high, irq_low}, {j[0], ~j[0]})
        end
        clr();
        conv(3'h0, 3'h3, 1'b1, 1'b0);
        cyc(2);
        `CHK(wake_req, 1'b1)
        sleep_mode = 1'b0;
        conv_irq_en = 1'b0;
        clr();
        conv(3'h0, 3'h3, 1'b1, 1'b0);
        cyc(40);
        `CHK({conv_done_flag, analog_on}, 2'h2)
        sleep_mode = 1'b0;
        $display("test interrupt and sleep done");
        clr();
        level = 10'h3c3;
        conv(3'h0, 3'h6, 1'b0, 1'b1);
        cyc(2);
        `CHK({conv_done_flag, discharging}, 2'h1)
        `CHK(result, fmt(10'h15b, 1'b1))
        conv(3'h0, 3'h6, 1'b1, 1'b0);
        `CHK(d < 10 && analog_on === 1'b0, 1'b1)
        `CHK(conv_done_flag, 1'b0)
        sleep_mode = 1'b0;
        $display("test abort done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
